// file: hw/pss_sram_access.sv
// access controller of a pipelined synchronous burst sram with byte lanes
// ============================================================================
// Summary of operation
// - clock qualify high at an edge: edge ignored, pipeline state held; sleep and mode synchronisers still advance
// - all synchronous pins captured in registers on the rising edge
// - read data leaves through an output register, never straight from array
// - new access: all selects active, qualify low, advance/load low
// - write strobe sampled with the address picks read or write
// - a write stores only lanes whose byte select is active
// - array write is timed internally on the clock, no write pulse needed
// - reads, writes and deselects share one pipeline, no wait states
// - read start: qualify low, selects active, strobe high, advance/load low
// - read word driven after the edge following address capture, if enabled
// - from second read cycle drivers need output enable and pipeline permit
// - next command may be issued in the read data cycle and is taken
// - on deselect the pins go undriven only after the next edge
// - sleep input gives a low power state keeping stored contents
// - output enable acts on the drivers without any clocking
// - select c active low, with select a active low and b high
// - output enable ignored in write data, first cycle after deselect, deselected
// - qualify high does not deselect; it only stretches the cycle
// - each parity lane written under its data byte select
`timescale 1ns/100ps

module pss_sram_access
(
  // clock and reset
  input  wire logic                    ref_clk,
  input  wire logic                    resetn,
  // synchronous control pins
  input  wire logic                    clockQualifyN,
  input  wire logic                    chipSelectAN,
  input  wire logic                    chipSelectB,
  input  wire logic                    chipSelectCN,
  input  wire logic                    advanceLoadN,
  input  wire logic                    writeStrobeN,
  input  wire pss_pkg::pss_lane_t      byteLaneWriteN,
  input  wire pss_pkg::pss_addr_t      address,
  // asynchronous and strap pins
  input  wire logic                    outputEnableN,
  input  wire logic                    sleepRequest,
  input  wire logic                    burstOrderInterleaved,
  // data pins
  input  wire logic [31:0]             dataIoIn,
  output logic [31:0]                  dataIoOut,
  output logic                         dataIoOe,
  input  wire pss_pkg::pss_lane_t      parityIoIn,
  output pss_pkg::pss_lane_t           parityIoOut,
  output logic                         parityIoOe,
  // status
  output logic                         sleepActive
);
  import pss_pkg::*;

  pss_state_s st_reg;
  pss_state_s st_next;
  pss_wr_s    wrReq;
  pss_word_t  arrayWord;
  pss_word_t  pinWord;
  pss_word_t  readWord;
  logic       qualified;
  logic       selected;
  logic       loadNew;
  logic       asleep;
  pss_burst_t cntNext;

  // ==========================================================================
  // pin decode
  assign qualified = !clockQualifyN;
  assign selected  = !chipSelectAN && chipSelectB && !chipSelectCN;
  assign loadNew   = !advanceLoadN;
  assign asleep    = st_reg.sleepSync;
  assign cntNext   = BURST_W'(st_reg.burstCnt + 2'h1);
  assign pinWord   = packWord(dataIoIn, parityIoIn);

  // write of the data cycle lands on the qualified edge that samples the pins
  assign wrReq.en    = qualified && st_reg.wrPend;
  assign wrReq.addr  = st_reg.wrAddr;
  assign wrReq.data  = pinWord;
  assign wrReq.maskN = st_reg.wrBwN;

  // a read right behind a write to the same word would see stale array data
  always_comb
  begin
    readWord = arrayWord;
    if (wrReq.en && wrReq.addr == st_reg.addr)
      readWord = mergeLanes(arrayWord, pinWord, wrReq.maskN);
  end

  pss_array u_array
  (
    .ref_clk (ref_clk),
    .wrReq   (wrReq),
    .rdAddr  (st_reg.addr),
    .rdWord  (arrayWord)
  );

  // ==========================================================================
  // next state
  always_comb
  begin
    st_next = st_reg;
    // sleep and strap pins are not clocked by the controller, so sync them
    st_next.sleepMeta = sleepRequest;
    st_next.sleepSync = st_reg.sleepMeta;
    st_next.modeMeta  = burstOrderInterleaved;
    st_next.modeSync  = st_reg.modeMeta;
    // unqualified edge: pipeline holds, nothing is deselected
    if (qualified)
    begin
      // data stage
      st_next.wrPend = (st_reg.op == OP_WRITE);
      st_next.wrAddr = st_reg.addr;
      st_next.wrBwN  = st_reg.bwN;
      st_next.drive  = (st_reg.op == OP_READ);
      if (st_reg.op == OP_READ)
        st_next.rdData = readWord;
      // address stage, taken on every qualified edge including data cycles
      if (asleep)
        st_next.op = OP_IDLE;
      else if (loadNew)
      begin
        if (selected)
        begin
          st_next.op        = writeStrobeN ? OP_READ : OP_WRITE;
          st_next.addr      = address;
          st_next.burstBase = address[BURST_W-1:0];
          st_next.burstCnt  = 2'h0;
          st_next.bwN       = byteLaneWriteN;
        end
        else
          st_next.op = OP_IDLE;
      end
      else if (st_reg.op != OP_IDLE)
      begin
        st_next.burstCnt = cntNext;
        st_next.addr[BURST_W-1:0] = burstLow(st_reg.burstBase, cntNext, st_reg.modeSync);
        st_next.bwN      = byteLaneWriteN;
      end
    end
  end

  // synchronous reset puts the pipeline idle; the array keeps its contents
  always_ff @(posedge ref_clk)
  begin
    if (!resetn)
      st_reg <= STATE_RST;
    else
      st_reg <= st_next;
  end

  // ==========================================================================
  // outputs
  // enable is combined without a clock so it can float the bus at once
  assign dataIoOe    = st_reg.drive && !outputEnableN && !asleep;
  assign parityIoOe  = dataIoOe;
  assign sleepActive = st_reg.sleepSync;

  always_comb
  begin
    for (int i = 0; i < LANES; i++)
    begin
      dataIoOut[i*BYTE_W +: BYTE_W] = st_reg.rdData[i*LANE_W +: BYTE_W];
      parityIoOut[i]                = st_reg.rdData[i*LANE_W + BYTE_W];
    end
  end

  // ==========================================================================
  // checks
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!resetn);

  sequence s_start;
    qualified && loadNew && selected && !asleep;
  endsequence

  sequence s_readStart;
    s_start and writeStrobeN;
  endsequence

  sequence s_writeStart;
    s_start and !writeStrobeN;
  endsequence

  property p_hold;
    !qualified |=> $stable(st_reg.op) && $stable(st_reg.addr) && $stable(st_reg.drive)
                   && $stable(st_reg.rdData) && $stable(st_reg.wrPend);
  endproperty
  a_hold: assert property (p_hold) else $error("state moved on unqualified edge");

  property p_capture;
    s_start |=> st_reg.addr == $past(address) && st_reg.op != OP_IDLE;
  endproperty
  a_capture: assert property (p_capture) else $error("address not captured");

  property p_type;
    s_start |=> (st_reg.op == OP_WRITE) == !$past(writeStrobeN);
  endproperty
  a_type: assert property (p_type) else $error("access type wrong");

  property p_readDrive;
    s_readStart ##1 qualified |=> st_reg.drive;
  endproperty
  a_readDrive: assert property (p_readDrive) else $error("read word not driven");

  property p_writeFloat;
    s_writeStart ##1 qualified |=> !dataIoOe;
  endproperty
  a_writeFloat: assert property (p_writeFloat) else $error("drive in write data");

  property p_deselect;
    qualified && loadNew && !selected ##1 qualified |=> !dataIoOe;
  endproperty
  a_deselect: assert property (p_deselect) else $error("drive after deselect");

  property p_enable;
    dataIoOe |-> st_reg.drive && !outputEnableN;
  endproperty
  a_enable: assert property (p_enable) else $error("drive without permit");

  property p_oeAsync;
    outputEnableN |-> !dataIoOe && !parityIoOe;
  endproperty
  a_oeAsync: assert property (p_oeAsync) else $error("output enable ignored");

  property p_sleep;
    qualified && asleep |=> st_reg.op == OP_IDLE;
  endproperty
  a_sleep: assert property (p_sleep) else $error("access taken in sleep");

  property p_burst;
    qualified && !loadNew && !asleep && st_reg.op != OP_IDLE |=> $stable(st_reg.op)
      && st_reg.addr[ADDR_W-1:BURST_W] == $past(st_reg.addr[ADDR_W-1:BURST_W]);
  endproperty
  a_burst: assert property (p_burst) else $error("burst did not continue");

endmodule

// file: common/pss_pkg.sv
// shared constants, types and helpers of the pipelined sync sram access block
package pss_pkg;

  // ==========================================================================
  // geometry
  localparam int ADDR_W  = 19;
  localparam int LANES   = 4;
  localparam int BYTE_W  = 8;
  localparam int LANE_W  = BYTE_W + 1;
  localparam int DATA_W  = LANES * BYTE_W;
  localparam int WORD_W  = LANES * LANE_W;
  localparam int DEPTH   = 1 << ADDR_W;
  localparam int BURST_W = 2;
  localparam int SYNC_STAGES = 2;

  typedef logic [ADDR_W-1:0]  pss_addr_t;
  typedef logic [WORD_W-1:0]  pss_word_t;
  typedef logic [LANES-1:0]   pss_lane_t;
  typedef logic [BURST_W-1:0] pss_burst_t;

  // ==========================================================================
  // operation held in the address stage
  typedef enum logic [1:0]
  {
    OP_IDLE  = 2'h0,
    OP_READ  = 2'h1,
    OP_WRITE = 2'h2
  } pss_op_e;

  // write request toward the array
  typedef struct packed
  {
    logic      en;
    pss_addr_t addr;
    pss_word_t data;
    pss_lane_t maskN;
  } pss_wr_s;

  // whole state of the access controller
  typedef struct packed
  {
    logic       sleepMeta;
    logic       sleepSync;
    logic       modeMeta;
    logic       modeSync;
    pss_op_e    op;
    pss_addr_t  addr;
    pss_burst_t burstBase;
    pss_burst_t burstCnt;
    pss_lane_t  bwN;
    logic       wrPend;
    pss_addr_t  wrAddr;
    pss_lane_t  wrBwN;
    logic       drive;
    pss_word_t  rdData;
  } pss_state_s;

  localparam pss_state_s STATE_RST = '0;

  // ==========================================================================
  // helpers
  // lane i of a word is {parity bit i, data byte i}
  function automatic pss_word_t packWord(input logic [DATA_W-1:0] d, input pss_lane_t p);
    pss_word_t w;
    w = '0;
    for (int i = 0; i < LANES; i++)
      w[i*LANE_W +: LANE_W] = {p[i], d[i*BYTE_W +: BYTE_W]};
    return w;
  endfunction

  // lanes with an active low select take the new value
  function automatic pss_word_t mergeLanes(input pss_word_t oldW, input pss_word_t newW,
                                           input pss_lane_t maskN);
    pss_word_t w;
    w = oldW;
    for (int i = 0; i < LANES; i++)
      if (!maskN[i])
        w[i*LANE_W +: LANE_W] = newW[i*LANE_W +: LANE_W];
    return w;
  endfunction

  // low address bits of a burst step, interleaved or linear
  function automatic pss_burst_t burstLow(input pss_burst_t base, input pss_burst_t cnt,
                                          input logic interleaved);
    return interleaved ? (base ^ cnt) : BURST_W'(base + cnt);
  endfunction

endpackage

// file: hw/pss_array.sv
// storage array with byte lane writes and an unregistered read port
`timescale 1ns/100ps

module pss_array
(
  // clock
  input  wire logic               ref_clk,
  // write port
  input  wire pss_pkg::pss_wr_s   wrReq,
  // read port
  input  wire pss_pkg::pss_addr_t rdAddr,
  output pss_pkg::pss_word_t      rdWord
);
  import pss_pkg::*;

  pss_word_t mem [DEPTH];
  pss_word_t oldWord;
  pss_word_t expWord;
  logic      wrEn;
  pss_addr_t wrAddr;

  // ==========================================================================
  // array
  // no reset: contents survive reset and sleep alike
  always_ff @(posedge ref_clk)
  begin
    if (wrReq.en)
      mem[wrReq.addr] <= mergeLanes(mem[wrReq.addr], wrReq.data, wrReq.maskN);
  end

  // read is combinational; the caller owns the output register
  assign rdWord  = mem[rdAddr];
  assign oldWord = mem[wrReq.addr];
  assign expWord = mergeLanes(oldWord, wrReq.data, wrReq.maskN);
  assign wrEn    = wrReq.en;
  assign wrAddr  = wrReq.addr;

  // ==========================================================================
  // checks
  property p_laneWrite;
    @(posedge ref_clk) wrEn |=> mem[$past(wrAddr)] == $past(expWord);
  endproperty
  a_laneWrite: assert property (p_laneWrite) else $error("byte lane write wrong");

endmodule

// file: test/pss_ctrl_model.sv
// memory controller model that drives the sram command and write data pins
`timescale 1ns/100ps

module pss_ctrl_model
(
  // clock
  input  wire logic          ref_clk,
  input  wire logic          clockQualifyN,
  // command pins
  output logic               chipSelectAN,
  output logic               chipSelectB,
  output logic               chipSelectCN,
  output logic               advanceLoadN,
  output logic               writeStrobeN,
  output pss_pkg::pss_lane_t byteLaneWriteN,
  output pss_pkg::pss_addr_t address,
  // write data pins, parity lanes on top
  output logic [35:0]        wrWord
);
  import pss_pkg::*;

  logic        loadWr;
  logic [35:0] loadWd;
  logic [1:0]  wrPipe;
  logic [35:0] wdPipe [2];

  // start deselected with nothing scheduled
  initial
  begin
    {chipSelectAN, chipSelectB, chipSelectCN, advanceLoadN, writeStrobeN} = 5'h15;
    byteLaneWriteN = '1;
    address = '0;
    wrWord = '0;
    loadWr = 1'b0;
    loadWd = '0;
    wrPipe = '0;
  end

  // one command per cycle: 0 deselect, 1 read, 2 write load; 3, 4 continue read, write burst
  task automatic issue(input int kind, input pss_addr_t a, input pss_lane_t m,
                       input logic [35:0] w, input int dsel);
    @(negedge ref_clk);
    chipSelectAN   <= kind == 0 && dsel == 0;
    chipSelectB    <= !(kind == 0 && dsel == 1);
    chipSelectCN   <= kind == 0 && dsel == 2;
    advanceLoadN   <= kind > 2;
    writeStrobeN   <= kind != 2;
    byteLaneWriteN <= m;
    address        <= a;
    loadWr         <= kind == 2 || kind == 4;
    loadWd         <= w;
  endtask

  // write data goes out two qualified edges after the load; a stall freezes it
  always @(posedge ref_clk)
    if (!clockQualifyN)
    begin
      wrPipe    <= {wrPipe[0], loadWr};
      wdPipe[1] <= wdPipe[0];
      wdPipe[0] <= loadWd;
    end

  // released pins toggle so a stale word can never pass for valid data
  always @(negedge ref_clk)
    wrWord <= wrPipe[1] ? wdPipe[1] : ~wrWord;
endmodule

// file: test/testbench.sv
// self-checking testbench of the pipelined sync sram access block
`timescale 1ns/100ps

module testbench;
  import pss_pkg::*;

  logic        ref_clk, resetn, clockQualifyN, outputEnableN, sleepRequest, burstMode;
  logic        chipSelectAN, chipSelectB, chipSelectCN, advanceLoadN, writeStrobeN;
  logic        dataIoOe, parityIoOe, sleepActive;
  logic [31:0] dataIoOut;
  logic [35:0] wrWord;
  logic [35:0] rdWord;
  pss_lane_t   byteLaneWriteN;
  pss_lane_t   parityIoOut;
  pss_addr_t   address;
  int          miscompares;
  int          nTests;

  assign rdWord = {parityIoOut, dataIoOut};

  // ==========================================================================
  // design and controller model
  pss_sram_access u_pss_sram_access (.ref_clk(ref_clk), .resetn(resetn),
    .clockQualifyN(clockQualifyN), .chipSelectAN(chipSelectAN), .chipSelectB(chipSelectB),
    .chipSelectCN(chipSelectCN), .advanceLoadN(advanceLoadN), .writeStrobeN(writeStrobeN),
    .byteLaneWriteN(byteLaneWriteN), .address(address), .outputEnableN(outputEnableN),
    .sleepRequest(sleepRequest), .burstOrderInterleaved(burstMode), .dataIoIn(wrWord[31:0]),
    .dataIoOut(dataIoOut), .dataIoOe(dataIoOe), .parityIoIn(wrWord[35:32]),
    .parityIoOut(parityIoOut), .parityIoOe(parityIoOe), .sleepActive(sleepActive));

  pss_ctrl_model u_pss_ctrl_model (.ref_clk(ref_clk), .clockQualifyN(clockQualifyN),
    .chipSelectAN(chipSelectAN), .chipSelectB(chipSelectB), .chipSelectCN(chipSelectCN),
    .advanceLoadN(advanceLoadN), .writeStrobeN(writeStrobeN),
    .byteLaneWriteN(byteLaneWriteN), .address(address), .wrWord(wrWord));

  // ==========================================================================
  // helpers
  task automatic check(input string what, input logic [39:0] seen, input logic [39:0] exp);
    nTests++;
    if (seen !== exp)
    begin
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
      miscompares++;
    end
  endtask

  task automatic summarize();
    $display("checks %0d mismatches %0d", nTests, miscompares);
    if (miscompares == 0 && nTests > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  // one cycle of the controller; step(0) is a deselect
  task automatic step(input int kind, input pss_addr_t a = '0, input pss_lane_t m = '1,
                      input logic [35:0] w = '0, input int dsel = 0);
    u_pss_ctrl_model.issue(kind, a, m, w, dsel);
  endtask

  // sleep status follows the request through a synchroniser; bounded wait
  task automatic waitSleep(input logic lvl);
    int n;
    n = 0;
    while (sleepActive !== lvl && n < 10)
    begin
      step(0);
      n++;
    end
    if (sleepActive !== lvl)
    begin
      check("sleepActive", sleepActive, lvl);
      summarize();
    end
  endtask

  // ==========================================================================
  // scenarios
  task automatic testWriteRead();
    step(2, 19'h00010, 4'h0, 36'h511223344);
    step(1, 19'h00010);
    step(0);
    check("drive in write data", {dataIoOe, parityIoOe}, 2'h0);
    step(0);
    check("read after write", rdWord, 36'h511223344);
    check("read drive", {dataIoOe, parityIoOe}, 2'h3);
    step(2, 19'h00010, 4'ha, 36'h0aabbccdd);
    repeat (2) step(0);
    step(1, 19'h00010);
    repeat (2) step(0);
    check("byte write", rdWord, 36'h011bb33dd);
    $display("write and read done");
  endtask

  task automatic testOe();
    outputEnableN <= 1'b1;
    step(1, 19'h00010);
    repeat (2) step(0);
    check("oe high", dataIoOe, 1'b0);
    outputEnableN <= 1'b0;
    #1 check("oe low at once", {dataIoOe, rdWord}, {1'b1, 36'h011bb33dd});
    $display("output enable done");
  endtask

  task automatic testDeselect();
    for (int d = 0; d < 3; d++)
    begin
      step(1, 19'h00010);
      step(1, 19'h00010);
      step(0, '0, '1, '0, d);
      step(0);
      check("drive before deselect lands", dataIoOe, 1'b1);
      step(0);
      check("drive after deselect", dataIoOe, 1'b0);
    end
    $display("deselect done");
  endtask

  task automatic testStall();
    step(1, 19'h00010);
    step(0);
    clockQualifyN <= 1'b1;
    repeat (3)
    begin
      step(0);
      check("stalled read", dataIoOe, 1'b0);
    end
    clockQualifyN <= 1'b0;
    step(0);
    check("resumed read", {dataIoOe, rdWord}, {1'b1, 36'h011bb33dd});
    $display("stall done");
  endtask

  // linear burst write from 0x21, then interleaved burst read back from 0x22
  task automatic testBurst();
    logic [35:0] wd [4];
    wd = '{36'h3c0000020, 36'h9c0000021, 36'h6c0000022, 36'hfc0000023};
    step(2, 19'h00021, 4'h0, wd[1]);
    for (int i = 2; i < 5; i++)
      step(4, '0, 4'h0, wd[i % 4]);
    // mode reaches the burst counter two edges later, after the last write step
    burstMode <= 1'b1;
    repeat (3) step(0);
    step(1, 19'h00022);
    step(3);
    for (int i = 0; i < 4; i++)
    begin
      step(i < 2 ? 3 : 0);
      check("burst read", {dataIoOe, rdWord}, {1'b1, wd[(i + 2) % 4]});
    end
    $display("burst done");
  endtask

  task automatic testSleep();
    sleepRequest <= 1'b1;
    waitSleep(1'b1);
    step(1, 19'h00010);
    repeat (2) step(0);
    check("read while asleep", dataIoOe, 1'b0);
    sleepRequest <= 1'b0;
    waitSleep(1'b0);
    repeat (2) step(0);
    step(1, 19'h00010);
    repeat (2) step(0);
    check("contents kept", rdWord, 36'h011bb33dd);
    $display("sleep done");
  endtask

  // ==========================================================================
  // clock and main sequence
  initial
  begin
    ref_clk = 1'b0;
    forever #2 ref_clk = ~ref_clk;
  end

  initial
  begin
    miscompares = 0;
    nTests = 0;
    resetn = 1'b0;
    clockQualifyN = 1'b0;
    outputEnableN = 1'b0;
    sleepRequest = 1'b0;
    burstMode = 1'b0;
    repeat (20) @(negedge ref_clk);
    check("reset outputs", {dataIoOe, parityIoOe, sleepActive, rdWord}, '0);
    resetn <= 1'b1;
    testWriteRead();
    testOe();
    testDeselect();
    testStall();
    testBurst();
    testSleep();
    summarize();
  end
endmodule
